/* File: logic/dnsl_pkg.sv */
// constants shared by the nco serial loader
package dnsl_pkg;
  localparam int ACC_W   = 28;
  localparam int PH_W    = 12;
  localparam int DAC_W   = 10;
  localparam int WORD_W  = 16;
  localparam int CTL_W   = 14;
  localparam int SEL_LAT = 8;
  // control register bit positions
  localparam int CB_B28   = 13;
  localparam int CB_HLB   = 12;
  localparam int CB_FREQ_SEL_BIT  = 11;
  localparam int CB_PSEL  = 10;
  localparam int CB_PINSW = 9;
  localparam int CB_RESET = 8;
  localparam int CB_OPEN  = 5;
  localparam int CB_SIGN  = 4;
  localparam int CB_DIV2  = 3;
  localparam int CB_MODE  = 1;
  // address codes in word bits 15:14 and 15:13
  localparam logic [1:0] AD_CTL  = 2'h0;
  localparam logic [1:0] AD_FA   = 2'h1;
  localparam logic [1:0] AD_FB   = 2'h2;
  localparam logic [1:0] AD_PH   = 2'h3;
  localparam logic [13:0] CTL_RST = 14'h0000;
  localparam logic [9:0] DAC_MID  = 10'h0200;
endpackage

/* File: logic/dnsl_core.sv */
// nco core with serial loader and axi4-lite status
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
module dnsl_core
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        frame_strobe_n,
  input  wire logic        serial_in,
  input  wire logic        freq_sel_pin,
  input  wire logic        phase_sel_pin,
  input  wire logic        reset_pin,
  input  wire logic        comp_in,
  output logic [9:0]       dac_code,
  output logic             sign_out,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ----------------------------------------
  // input synchronisers, three flops each
  // ----------------------------------------
  logic [2:0] sck_s_r, fs_s_r, sd_s_r, fp_s_r, pp_s_r, rp_s_r, cp_s_r;
  logic sck_q_r, fs_q_r, fp_q_r, pp_q_r, rp_q_r, cp_q_r;
  always_ff @(posedge ref_clk)
  begin
    sck_s_r <= {sck_s_r[1:0], sclk};
    fs_s_r  <= {fs_s_r[1:0], frame_strobe_n};
    sd_s_r  <= {sd_s_r[1:0], serial_in};
    fp_s_r  <= {fp_s_r[1:0], freq_sel_pin};
    pp_s_r  <= {pp_s_r[1:0], phase_sel_pin};
    rp_s_r  <= {rp_s_r[1:0], reset_pin};
    cp_s_r  <= {cp_s_r[1:0], comp_in};
  end
  // accept a level once stages two and three agree
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sck_q_r <= 1'b1;
      fs_q_r  <= 1'b1;
      fp_q_r  <= 1'b0;
      pp_q_r  <= 1'b0;
      rp_q_r  <= 1'b0;
      cp_q_r  <= 1'b0;
    end
    else
    begin
      if (sck_s_r[1] == sck_s_r[2]) sck_q_r <= sck_s_r[2];
      if (fs_s_r[1] == fs_s_r[2])   fs_q_r  <= fs_s_r[2];
      if (fp_s_r[1] == fp_s_r[2])   fp_q_r  <= fp_s_r[2];
      if (pp_s_r[1] == pp_s_r[2])   pp_q_r  <= pp_s_r[2];
      if (rp_s_r[1] == rp_s_r[2])   rp_q_r  <= rp_s_r[2];
      if (cp_s_r[1] == cp_s_r[2])   cp_q_r  <= cp_s_r[2];
    end
  end

  // ----------------------------------------
  // serial shifter
  // ----------------------------------------
  logic        sck_fall;
  logic [15:0] shf_r;   // shift register
  logic [3:0]  cnt_r;   // bits in current word
  logic        wdone_r; // one-cycle word pulse
  logic [15:0] word_r;  // completed word
  // falling sclk seen while strobe low
  assign sck_fall = sck_q_r && (sck_s_r[2] == 1'b0)
                    && (sck_s_r[1] == 1'b0) && !fs_q_r;
  // shift on falling edges, flush on strobe high
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      shf_r   <= 16'h0000;
      cnt_r   <= 4'h0;
      wdone_r <= 1'b0;
      word_r  <= 16'h0000;
    end
    else
    begin
      wdone_r <= 1'b0;
      if (fs_q_r)
        cnt_r <= 4'h0;
      else if (sck_fall)
      begin
        shf_r <= {shf_r[14:0], sd_s_r[2]};
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == 4'hf)
        begin
          wdone_r <= 1'b1;
          word_r  <= {shf_r[14:0], sd_s_r[2]};
        end
      end
    end
  end

  // ----------------------------------------
  // register writes from words
  // ----------------------------------------
  logic [13:0] ctl_r;
  logic [27:0] fa_r, fb_r;
  logic [11:0] pa_r, pb_r;
  logic [13:0] lsb_hold_r;   // pending b28 low half
  logic        half_r;       // b28 first half stored
  logic [27:0] fw_cur, fw_nxt;
  logic        is_b, use_hi;
  assign is_b = (word_r[15:14] == dnsl_pkg::AD_FB);
  assign fw_cur = is_b ? fb_r : fa_r;
  assign use_hi = ctl_r[dnsl_pkg::CB_HLB];
  assign fw_nxt = ctl_r[dnsl_pkg::CB_B28] ?
                  {word_r[13:0], lsb_hold_r} :
                  (use_hi ? {word_r[13:0], fw_cur[13:0]}
                          : {fw_cur[27:14], word_r[13:0]});
  // decode address bits and update a register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctl_r      <= dnsl_pkg::CTL_RST;
      fa_r       <= 28'h000_0000;
      fb_r       <= 28'h000_0000;
      pa_r       <= 12'h000;
      pb_r       <= 12'h000;
      lsb_hold_r <= 14'h0000;
      half_r     <= 1'b0;
    end
    else if (wdone_r)
    begin
      unique case (word_r[15:14])
        dnsl_pkg::AD_CTL: ctl_r <= word_r[13:0];
        dnsl_pkg::AD_PH:
          if (word_r[13]) pb_r <= word_r[11:0];
          else            pa_r <= word_r[11:0];
        default:
          if (ctl_r[dnsl_pkg::CB_B28] && !half_r)
          begin
            lsb_hold_r <= word_r[13:0];
            half_r     <= 1'b1;
          end
          else
          begin
            half_r <= 1'b0;
            if (is_b) fb_r <= fw_nxt;
            else      fa_r <= fw_nxt;
          end
      endcase
    end
  end

  // ----------------------------------------
  // nco datapath, eight-stage select latency
  // ----------------------------------------
  logic freq_sel_bit, psel, nco_rst;
  logic [7:0] fdly_r, pdly_r;
  assign freq_sel_bit = ctl_r[dnsl_pkg::CB_PINSW] ? fp_q_r
                : ctl_r[dnsl_pkg::CB_FREQ_SEL_BIT];
  assign psel = ctl_r[dnsl_pkg::CB_PINSW] ? pp_q_r
                : ctl_r[dnsl_pkg::CB_PSEL];
  assign nco_rst = rp_q_r || ctl_r[dnsl_pkg::CB_RESET];
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fdly_r <= 8'h00;
      pdly_r <= 8'h00;
    end
    else
    begin
      fdly_r <= {fdly_r[6:0], freq_sel_bit};
      pdly_r <= {pdly_r[6:0], psel};
    end
  end
  logic [27:0] acc_r;
  logic [11:0] ph_r;
  logic [9:0]  amp;
  logic [11:0] poff;
  // offset added to top 12 bits
  assign poff = pdly_r[7] ? pb_r : pa_r;
  function automatic logic [9:0] dnsl_sine(input logic [11:0] p);
    logic [10:0] q;
    logic [21:0] sq;
    logic [9:0]  m;
    q  = p[10] ? (11'h400 - {1'b0, p[9:0]}) : {1'b0, p[9:0]};
    sq = q * q;
    m  = 10'(({11'h000, q} * 22'd3 / 22'd2 - sq[21:11]) >> 1);
    return p[11] ? 10'(10'h200 - m) : 10'(10'h200 + m - 10'h001 * m[9]);
  endfunction
  assign amp = dnsl_sine(ph_r);
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || nco_rst)
    begin
      acc_r    <= 28'h000_0000;
      ph_r     <= 12'h000;
      dac_code <= dnsl_pkg::DAC_MID;
      sign_out <= 1'b0;
    end
    else
    begin
      acc_r <= acc_r + (fdly_r[7] ? fb_r : fa_r);
      ph_r  <= acc_r[27:16] + poff;
      if (ctl_r[dnsl_pkg::CB_OPEN] || !ctl_r[dnsl_pkg::CB_MODE])
        dac_code <= amp;
      else
        dac_code <= ph_r[11] ? ~ph_r[10:1] : ph_r[10:1];
      // comparator or msb to sign pin
      if (!ctl_r[dnsl_pkg::CB_OPEN])
        sign_out <= 1'b0;
      else if (ctl_r[dnsl_pkg::CB_SIGN])
        sign_out <= cp_q_r;
      else
        sign_out <= ph_r[11];
    end
  end

  // ----------------------------------------
  // axi4-lite status slave, read only
  // ----------------------------------------
  logic aw_r, w_r;
  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // writes answered slverr, reads give state
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready) aw_r <= 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_r <= 1'b1;
      if (aw_r && w_r && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h2;
        aw_r <= 1'b0;
        w_r <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr[3:2])
          2'h0: s_axi_rdata <= {18'h0_0000, ctl_r};
          2'h1: s_axi_rdata <= {4'h0, acc_r};
          2'h2: s_axi_rdata <= {20'h0_0000, ph_r};
          2'h3: s_axi_rdata <= {22'h00_0000, dac_code};
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(nco_rst) && !nco_rst |-> acc_r == 28'($past(acc_r) + $past(fdly_r[7] ? fb_r : fa_r)))
    else $error("accumulator step wrong");
  AST_MID: assert property (@(posedge ref_clk) disable iff (!rst_n)
    nco_rst |=> dac_code == dnsl_pkg::DAC_MID)
    else $error("reset not midscale");
  AST_SIGN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !nco_rst && ctl_r[dnsl_pkg::CB_OPEN] && ctl_r[dnsl_pkg::CB_SIGN] |=> sign_out == $past(cp_q_r))
    else $error("comparator not routed");
  AST_SHORT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    fs_q_r |=> !wdone_r)
    else $error("word after strobe high");
  COV_WORD: cover property (@(posedge ref_clk) wdone_r);
  COV_B28: cover property (@(posedge ref_clk) wdone_r && half_r);
  COV_SIGN: cover property (@(posedge ref_clk) sign_out);
endmodule

/* File: bench/dnsl_host.sv */
// serial host model for the frame port
module dnsl_host
(
  input  wire logic ref_clk,
  output logic      sclk,
  output logic      frame_strobe_n,
  output logic      serial_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels: clock high, frame closed
  initial
  begin
    sclk = 1'b1;
    frame_strobe_n = 1'b1;
    serial_in = 1'b0;
  end
  // one half period of the serial clock
  task automatic half();
    repeat (5) @(posedge ref_clk);
  endtask
  // n bits of d, msb first, in one frame
  task automatic frame(input logic [31:0] d, input int n);
    half();
    frame_strobe_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_in <= d[i];
      half();
      sclk <= 1'b0;
      half();
      sclk <= 1'b1;
    end
    half();
    frame_strobe_n <= 1'b1;
    // released line shows inverse level
    serial_in <= ~serial_in;
  endtask
endmodule

/* File: bench/dds_nco_serial_loader_tb_top.sv */
// self-checking bench for the nco serial loader
module dds_nco_serial_loader_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // signals
  // ----
  logic        ref_clk, rst_n, freq_sel_pin, reset_pin, comp_in;
  logic        sclk, frame_strobe_n, serial_in, sign_out;
  logic [9:0]  dac_code;
  logic [3:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          miscompares, compares, cyc, t_ar;
  dnsl_host u_dnsl_host (.ref_clk, .sclk, .frame_strobe_n, .serial_in);
  dnsl_core u_dnsl_core (.ref_clk, .rst_n, .sclk, .frame_strobe_n,
    .serial_in, .freq_sel_pin, .phase_sel_pin(1'b0), .reset_pin,
    .comp_in, .dac_code, .sign_out, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // clock and cycle ceiling
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  // ----
  // tasks
  // ----
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // axi read: hold until taken, data at rvalid
  task automatic rd32(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    t_ar = cyc;
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  // axi write: both channels offered together
  task automatic wr32(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge ref_clk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // bounded read poll, then compare
  task automatic poll(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    for (int i = 0; i < 32; i++)
    begin
      rd32(a, d);
      if (d === e)
        break;
    end
    chk(nm, e, d);
  endtask
  // accumulator step between two timed reads
  task automatic rate(input logic [27:0] f);
    logic [31:0] a1, a2;
    int          t1;
    rd32(4'h4, a1);
    t1 = t_ar;
    rd32(4'h4, a2);
    chk("acc_step", {4'h0, f * 28'(t_ar - t1)}, {4'h0, a2[27:0] - a1[27:0]});
  endtask
  // bounded wait on the sign pin
  task automatic sig(input logic e);
    for (int i = 0; i < 16 && sign_out !== e; i++)
      @(posedge ref_clk);
    chk("sign_out", {31'h0, e}, {31'h0, sign_out});
  endtask
  // ----
  // tests
  // ----
  initial
  begin
    {rst_n, freq_sel_pin, reset_pin, comp_in, cyc} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, miscompares, compares} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    poll("ctl", 4'h0, {18'h0, dnsl_pkg::CTL_RST});
    poll("dac", 4'hC, {22'h0, dnsl_pkg::DAC_MID});
    $display("test reset done");
    u_dnsl_host.frame(32'h2000_2000, 32);
    poll("ctl", 4'h0, 32'h0000_2000);
    u_dnsl_host.frame(32'h0000_0028, 8);
    rd32(4'h0, rd);
    chk("ctl", 32'h0000_2000, rd);
    u_dnsl_host.frame(32'h2010_2010, 32);
    poll("ctl", 4'h0, 32'h0000_2010);
    $display("test serial done");
    u_dnsl_host.frame(32'h4001_7000, 32);
    repeat (20) @(posedge ref_clk);
    rate(28'hC00_0001);
    u_dnsl_host.frame(32'h8003_8000, 32);
    u_dnsl_host.frame(32'h2810_2810, 32);
    poll("ctl", 4'h0, 32'h0000_2810);
    rate(28'h000_0003);
    $display("test freq done");
    u_dnsl_host.frame(32'h2210_2210, 32);
    poll("ctl", 4'h0, 32'h0000_2210);
    rate(28'hC00_0001);
    freq_sel_pin <= 1'b1;
    repeat (dnsl_pkg::SEL_LAT + 4) @(posedge ref_clk);
    rate(28'h000_0003);
    $display("test pin done");
    u_dnsl_host.frame(32'h2030_2030, 32);
    poll("ctl", 4'h0, 32'h0000_2030);
    comp_in <= 1'b1;
    sig(1'b1);
    comp_in <= 1'b0;
    sig(1'b0);
    $display("test sign done");
    reset_pin <= 1'b1;
    repeat (12) @(posedge ref_clk);
    poll("acc", 4'h4, 32'h0);
    poll("dac", 4'hC, {22'h0, dnsl_pkg::DAC_MID});
    rd32(4'h0, rd);
    chk("ctl", 32'h0000_2030, rd);
    reset_pin <= 1'b0;
    wr32(4'h0, 32'h0000_FFFF, s_axi_bresp);
    $display("test reset pin done");
    end_sim();
  end
endmodule
